/* dfs_pkg.sv */
// Purpose: Shared constants for the DPLL frequency and source valid status block
// Assumes: APB register access, word per register, byte address = 4 x index
// Notes: How it works list below
// How it works
// - Mid frequency byte is read-only, resets zero
// - Selector bit picks monitor or second path
// - Three bytes form one 24-bit offset word
// - Offset word is two's complement signed
// - Freeze enable holds value at limit
// - Valid unless a non-soft alarm is outstanding
// - Inputs 1..8 map onto bits 0..7
// - Valid flag reads one, invalid reads zero
package dfs_pkg;
    // Bus shape
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int IDX_W = 8;
    // Frequency word and input count
    localparam int FREQ_W = 24;
    localparam int NUM_INPUTS = 8;
    localparam int MID_LSB = 8;
    localparam int MID_MSB = 15;
    // Register indices, byte address is index times four
    localparam logic [7:0] IDX_FREQ_MID = 8'h0d;
    localparam logic [7:0] IDX_VALID_LOW = 8'h0e;
    localparam logic [7:0] IDX_INT_STATUS = 8'h20;
    localparam logic [7:0] IDX_INT_MASK = 8'h21;
    localparam logic [7:0] IDX_FREEZE_CFG = 8'h3b;
    localparam logic [7:0] IDX_PATH_CFG = 8'h4b;
    // Field positions
    localparam int FREEZE_EN_BIT = 3;
    localparam int PATH_SEL_BIT = 4;
    localparam int INT_W = 9;
    localparam int INT_FREEZE_BIT = 8;
    // Reset values
    localparam logic [23:0] FREQ_RST = 24'h000000;
    localparam logic [7:0] VALID_RST = 8'h00;
    localparam logic [8:0] INT_RST = 9'h000;
endpackage

/* dfs_valid_qual.sv */
// Purpose: Per-input validity qualification from alarm flags
// Assumes: Alarm flags come from logic on the same clock
// Notes: Soft frequency alarms never invalidate an input
`timescale 1ns/1ns
module dfs_valid_qual
    import dfs_pkg::*;
#(
    parameter int N = NUM_INPUTS
) (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Alarm flags, one per input
    input wire logic [N-1:0] softFreqAlarm,
    input wire logic [N-1:0] hardAlarm,
    // Qualified results
    output logic [N-1:0] validVec,
    output logic [N-1:0] validChange
);
    // Whole state of this module
    typedef struct packed {
        logic [N-1:0] valid;
        logic [N-1:0] chg;
    } dfs_qual_s;

    dfs_qual_s stateReg;
    dfs_qual_s stateNext;
    logic [N-1:0] rawValid; // Combinational verdict per input

    // One qualifier per input
    genvar gi;
    generate
        for (gi = 0; gi < N; gi++) begin : g_in
            // No alarm at all, or only the soft one
            assign rawValid[gi] = !(hardAlarm[gi] | softFreqAlarm[gi])
                                | (softFreqAlarm[gi] & !hardAlarm[gi]);
        end
    endgenerate

    // Next state
    always_comb begin
        stateNext = stateReg;
        stateNext.valid = rawValid;
        stateNext.chg = rawValid ^ stateReg.valid;
    end

    // State register
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            stateReg <= '{valid: VALID_RST[N-1:0], chg: '0};
        end else begin
            stateReg <= stateNext;
        end
    end

    assign validVec = stateReg.valid;
    assign validChange = stateReg.chg;

    // Hard alarm always clears the flag next cycle
    a_valid_hard_alarm: assert property (@(posedge clock) disable iff (!nrst)
        (hardAlarm != '0) |=> ((validVec & $past(hardAlarm)) == '0))
        else $error("input with hard alarm reported valid");

    // Flag is one exactly when no hard alarm was seen
    a_valid_levels: assert property (@(posedge clock) disable iff (!nrst)
        ##1 (validVec == ~$past(hardAlarm)))
        else $error("validity flag level wrong");
endmodule

/* dfs_status_regs.sv */
// Purpose: APB status bank for reported DPLL frequency and input validity
// Assumes: DPLL integral values and alarms are on the same clock
// Notes: One wait state on every APB access; unmapped addresses raise pslverr
`timescale 1ns/1ns
module dfs_status_regs
    import dfs_pkg::*;
#(
    parameter int N = NUM_INPUTS
) (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // DPLL integral path values and limit flags
    input wire logic [FREQ_W-1:0] monitorFreq,
    input wire logic [FREQ_W-1:0] secondPathFreq,
    input wire logic monitorAtLimit,
    input wire logic secondAtLimit,
    // Per-input alarms
    input wire logic [N-1:0] softFreqAlarm,
    input wire logic [N-1:0] hardAlarm,
    // Results
    output logic [FREQ_W-1:0] reportedPllFreqOffset,
    output logic irq
);
    // Whole state of the bank
    typedef struct packed {
        logic [FREQ_W-1:0] freq;   // Reported signed offset word
        logic frozen;              // Hold active last cycle
        logic pathSel;             // 0 monitor, 1 second path
        logic freezeEn;            // Hold at limit enable
        logic [INT_W-1:0] intStatus;
        logic [INT_W-1:0] intMask;
        logic [DATA_W-1:0] rdata;  // Latched read data
        logic slvErr;              // Latched error answer
        logic done;                // Answer ready this cycle
    } dfs_main_s;

    dfs_main_s stateReg;
    dfs_main_s stateNext;

    // Validity qualifier outputs
    logic [N-1:0] validVec;
    logic [N-1:0] validChange;

    // Address decode helpers
    logic [IDX_W-1:0] addrIdx;  // Word index of the access
    logic addrAligned;          // Low bits and high bits are zero
    logic [DATA_W-1:0] rdMux;   // Read value before latching
    logic mapped;               // Index names a register
    logic accessStart;          // First access cycle
    logic writeNow;             // Write takes effect this edge

    // Frequency path helpers
    logic [FREQ_W-1:0] pickFreq; // Selected integral path value
    logic pickLimit;             // Selected DPLL sits at a limit
    logic holdNow;               // Report held this cycle
    logic [INT_W-1:0] intSet;    // Events raised this cycle
    logic [INT_W-1:0] intClr;    // Software clear mask

    // Validity qualification
    dfs_valid_qual #(
        .N(N)
    ) u_qual (
        .clock(clock),
        .nrst(nrst),
        .softFreqAlarm(softFreqAlarm),
        .hardAlarm(hardAlarm),
        .validVec(validVec),
        .validChange(validChange)
    );

    // Source selection and freeze decision
    always_comb begin
        // Integral path value, so an average, not instantaneous
        pickFreq = stateReg.pathSel ? secondPathFreq : monitorFreq;
        pickLimit = stateReg.pathSel ? secondAtLimit : monitorAtLimit;
        holdNow = stateReg.freezeEn & pickLimit;
    end

    // Address decode; word aligned, nothing above the index field
    always_comb begin
        addrIdx = paddr[IDX_W+1:2];
        addrAligned = (paddr[1:0] == 2'b00) && (paddr[ADDR_W-1:IDX_W+2] == '0);
        accessStart = psel & penable & !stateReg.done;
        writeNow = psel & penable & stateReg.done & pwrite;
    end

    // Read multiplexer
    always_comb begin
        rdMux = '0;
        mapped = addrAligned;
        case (addrIdx)
            // Middle byte of the signed word; top and bottom live elsewhere
            IDX_FREQ_MID: rdMux[7:0] = stateReg.freq[MID_MSB:MID_LSB];
            // Input 1 in bit 0 up to input 8 in bit 7
            IDX_VALID_LOW: rdMux[N-1:0] = validVec;
            IDX_INT_STATUS: rdMux[INT_W-1:0] = stateReg.intStatus;
            IDX_INT_MASK: rdMux[INT_W-1:0] = stateReg.intMask;
            IDX_FREEZE_CFG: rdMux[FREEZE_EN_BIT] = stateReg.freezeEn;
            IDX_PATH_CFG: rdMux[PATH_SEL_BIT] = stateReg.pathSel;
            default: mapped = 1'b0;
        endcase
        if (!mapped) begin
            // Unmapped reads return zero
            rdMux = '0;
        end
    end

    // Interrupt events and clear
    always_comb begin
        intSet = '0;
        intSet[N-1:0] = validChange;
        // Entering hold is worth telling software about
        intSet[INT_FREEZE_BIT] = holdNow & !stateReg.frozen;
        intClr = '0;
        if (writeNow && mapped && addrIdx == IDX_INT_STATUS) begin
            intClr = pwdata[INT_W-1:0];
        end
    end

    // Next state
    always_comb begin
        stateNext = stateReg;
        stateNext.frozen = holdNow;
        // Update unless held at a limit
        if (!holdNow) begin
            stateNext.freq = pickFreq;
        end
        // Set wins over a simultaneous clear
        stateNext.intStatus = (stateReg.intStatus & ~intClr) | intSet;
        // Access phase: first cycle latches the answer, second completes it
        if (accessStart) begin
            stateNext.done = 1'b1;
            stateNext.rdata = pwrite ? '0 : rdMux;
            stateNext.slvErr = !mapped;
        end else begin
            stateNext.done = 1'b0;
            stateNext.slvErr = 1'b0;
        end
        // Writes land on the completing edge; read-only words ignore them
        if (writeNow && mapped) begin
            case (addrIdx)
                IDX_INT_MASK: stateNext.intMask = pwdata[INT_W-1:0];
                IDX_FREEZE_CFG: stateNext.freezeEn = pwdata[FREEZE_EN_BIT];
                IDX_PATH_CFG: stateNext.pathSel = pwdata[PATH_SEL_BIT];
                default: begin
                    // Status handled above, others read-only
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            stateReg <= '{freq: FREQ_RST, frozen: 1'b0, pathSel: 1'b0, freezeEn: 1'b0,
                          intStatus: INT_RST, intMask: INT_RST, rdata: '0,
                          slvErr: 1'b0, done: 1'b0};
        end else begin
            stateReg <= stateNext;
        end
    end

    // Outputs
    assign prdata = stateReg.rdata;
    assign pready = stateReg.done;
    assign pslverr = stateReg.slvErr;
    assign reportedPllFreqOffset = stateReg.freq;
    // Level interrupt while an unmasked status bit stands
    assign irq = |(stateReg.intStatus & stateReg.intMask);

    // Mid byte read returns the word bits held at latch time
    a_mid_byte_read: assert property (@(posedge clock) disable iff (!nrst)
        (psel && penable && pready && !pwrite && addrAligned && addrIdx == IDX_FREQ_MID)
        |-> (prdata[7:0] == $past(stateReg.freq[MID_MSB:MID_LSB])) && (prdata[31:8] == '0))
        else $error("mid frequency byte read wrong");

    // Unheld report follows the selected path
    a_source_select: assert property (@(posedge clock) disable iff (!nrst)
        !$past(holdNow) |-> (stateReg.freq == $past(pickFreq)))
        else $error("reported frequency not from selected path");

    // Sign follows the source word when not held
    a_signed_word: assert property (@(posedge clock) disable iff (!nrst)
        !$past(holdNow) |-> (($signed(stateReg.freq) < 0) == ($signed($past(pickFreq)) < 0)))
        else $error("sign of reported word wrong");

    // Held value does not move
    a_freeze_hold: assert property (@(posedge clock) disable iff (!nrst)
        $past(holdNow) |-> $stable(stateReg.freq))
        else $error("reported frequency moved while frozen");

    // Report equals integral input of the monitor path when selected and not held
    a_integral_path: assert property (@(posedge clock) disable iff (!nrst)
        ($past(!stateReg.pathSel) && !$past(holdNow)) |-> (stateReg.freq == $past(monitorFreq)))
        else $error("monitor integral value not reported");

    // Valid byte read carries inputs 1..8 in bits 0..7
    a_valid_bit_map: assert property (@(posedge clock) disable iff (!nrst)
        (psel && penable && pready && !pwrite && addrAligned && addrIdx == IDX_VALID_LOW)
        |-> (prdata[N-1:0] == $past(validVec)) && (prdata[31:N] == '0))
        else $error("valid byte read wrong");

    // Change of validity leaves a sticky status bit
    a_valid_sticky: assert property (@(posedge clock) disable iff (!nrst)
        (validChange != '0) |=> ((stateReg.intStatus[N-1:0] & $past(validChange)) == $past(validChange)))
        else $error("validity change not latched");

    // Every access is answered one cycle after it starts
    a_apb_one_wait: assert property (@(posedge clock) disable iff (!nrst)
        (psel && penable && !pready) |=> pready)
        else $error("access not answered after one wait");

    // Completing edge of an access, shared by the bus checks below
    logic apbDone; // Select, enable and ready all high
    assign apbDone = psel & penable & pready;

    // Ready stands for the completing cycle only
    a_ready_one_cycle: assert property (@(posedge clock) disable iff (!nrst)
        pready |=> !pready)
        else $error("ready held longer than one cycle");

    // Error answer only comes with ready
    a_error_with_ready: assert property (@(posedge clock) disable iff (!nrst)
        pslverr |-> pready)
        else $error("error raised without ready");

    // Ready only answers an access that was already running
    a_ready_after_access: assert property (@(posedge clock) disable iff (!nrst)
        pready |-> $past(psel && penable))
        else $error("ready without a running access");

    // Unmapped or misaligned index is refused with an error
    a_unmapped_error: assert property (@(posedge clock) disable iff (!nrst)
        (psel && penable && !pready && !mapped) |=> pslverr)
        else $error("unmapped access not refused");

    // A refused access returns zero data
    a_refused_zero: assert property (@(posedge clock) disable iff (!nrst)
        (pready && pslverr) |-> (prdata == '0))
        else $error("refused access returned data");

    // Write answers carry no data
    a_write_no_data: assert property (@(posedge clock) disable iff (!nrst)
        (apbDone && pwrite) |-> (prdata == '0))
        else $error("write answer carried data");

    // Mid byte read is answered without error
    a_mid_read_ok: assert property (@(posedge clock) disable iff (!nrst)
        (apbDone && addrAligned && addrIdx == IDX_FREQ_MID) |-> !pslverr)
        else $error("mid frequency byte read refused");

    // Valid byte read is answered without error
    a_valid_read_ok: assert property (@(posedge clock) disable iff (!nrst)
        (apbDone && addrAligned && addrIdx == IDX_VALID_LOW) |-> !pslverr)
        else $error("valid byte read refused");

    // Inputs under a hard alarm never read as valid; two cycles from alarm to data
    a_valid_hard_read: assert property (@(posedge clock) disable iff (!nrst)
        (apbDone && !pwrite && addrAligned && addrIdx == IDX_VALID_LOW)
        |-> ((prdata[N-1:0] & $past(hardAlarm, 2)) == '0))
        else $error("input with hard alarm read as valid");

    // Write to the read-only word leaves all settings alone
    a_ro_write_kept: assert property (@(posedge clock) disable iff (!nrst)
        (apbDone && pwrite && addrAligned && addrIdx == IDX_FREQ_MID)
        |=> ($stable(stateReg.intMask) && $stable(stateReg.pathSel) && $stable(stateReg.freezeEn)))
        else $error("read-only write changed a setting");

    // Path select write lands on the completing edge
    a_path_write: assert property (@(posedge clock) disable iff (!nrst)
        (apbDone && pwrite && addrAligned && addrIdx == IDX_PATH_CFG)
        |=> (stateReg.pathSel == $past(pwdata[PATH_SEL_BIT])))
        else $error("path select write lost");

    // Path config reads back only the select bit
    a_path_read: assert property (@(posedge clock) disable iff (!nrst)
        (apbDone && !pwrite && addrAligned && addrIdx == IDX_PATH_CFG)
        |-> (prdata == (DATA_W'($past(stateReg.pathSel)) << PATH_SEL_BIT)))
        else $error("path config read wrong");

    // Freeze enable write lands on the completing edge
    a_freeze_write: assert property (@(posedge clock) disable iff (!nrst)
        (apbDone && pwrite && addrAligned && addrIdx == IDX_FREEZE_CFG)
        |=> (stateReg.freezeEn == $past(pwdata[FREEZE_EN_BIT])))
        else $error("freeze enable write lost");

    // Freeze config reads back only the enable bit
    a_cfg_read_bits: assert property (@(posedge clock) disable iff (!nrst)
        (apbDone && !pwrite && addrAligned && addrIdx == IDX_FREEZE_CFG)
        |-> (prdata == (DATA_W'($past(stateReg.freezeEn)) << FREEZE_EN_BIT)))
        else $error("freeze config read wrong");

    // Mask write lands on the completing edge
    a_mask_write: assert property (@(posedge clock) disable iff (!nrst)
        (apbDone && pwrite && addrAligned && addrIdx == IDX_INT_MASK)
        |=> (stateReg.intMask == $past(pwdata[INT_W-1:0])))
        else $error("mask write lost");

    // Writing ones clears status unless a new event lands
    a_status_clear: assert property (@(posedge clock) disable iff (!nrst)
        (apbDone && pwrite && addrAligned && addrIdx == IDX_INT_STATUS)
        |=> ((stateReg.intStatus & $past(pwdata[INT_W-1:0]) & ~$past(intSet)) == '0))
        else $error("status bits not cleared");

    // Every event leaves its sticky bit, clear or not
    a_set_wins: assert property (@(posedge clock) disable iff (!nrst)
        (intSet != '0) |=> ((stateReg.intStatus & $past(intSet)) == $past(intSet)))
        else $error("event lost against a clear");

    // Status bits only rise on an event
    a_status_no_spurious: assert property (@(posedge clock) disable iff (!nrst)
        (stateReg.intStatus & ~$past(stateReg.intStatus) & ~$past(intSet)) == '0)
        else $error("status bit set without an event");

    // Entering hold raises the hold status bit
    a_hold_event: assert property (@(posedge clock) disable iff (!nrst)
        (holdNow && !stateReg.frozen) |=> stateReg.intStatus[INT_FREEZE_BIT])
        else $error("hold entry not flagged");

    // Clearing the mask drops the interrupt next cycle
    a_irq_masked_off: assert property (@(posedge clock) disable iff (!nrst)
        (apbDone && pwrite && addrAligned && addrIdx == IDX_INT_MASK && pwdata[INT_W-1:0] == '0) |=> !irq)
        else $error("interrupt stayed up with mask cleared");

    // Second path value reported when selected and not held; skips the edge leaving reset
    a_second_path: assert property (@(posedge clock) disable iff (!nrst)
        ($past(nrst) && $past(stateReg.pathSel) && !$past(holdNow))
        |-> (stateReg.freq == $past(secondPathFreq)))
        else $error("second path value not reported");

    // Away from a limit the report always follows its source
    a_no_limit_free: assert property (@(posedge clock) disable iff (!nrst)
        ($past(nrst) && !$past(pickLimit)) |-> (stateReg.freq == $past(pickFreq)))
        else $error("report held away from a limit");
endmodule

/* dfs_status_regs_bench.sv */
// Purpose: Self-checking bench for the APB frequency and input validity status bank
// Assumes: One wait state per APB access, alarms and DPLL values on the bench clock
// Notes: Each scenario is a task; expected values come from fixed patterns only
`timescale 1ns/1ns
module dfs_status_regs_bench;
    import dfs_pkg::*;
    // Compare two values, count and report
    `define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin miscompares++; \
        $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
    // Clock and reset
    logic clock = 1'b0;
    logic nrst = 1'b0;
    // APB master side
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0, prdata;
    logic pready, pslverr, irq;
    // DPLL values, limits and alarms; all inputs start invalid
    logic [FREQ_W-1:0] monitorFreq = '0, secondPathFreq = '0, reportedPllFreqOffset;
    logic monitorAtLimit = 1'b0, secondAtLimit = 1'b0;
    logic [7:0] softFreqAlarm = 8'h00, hardAlarm = 8'hff;
    int miscompares = 0, n_compared = 0;
    logic [31:0] rdat;
    logic rerr;

    // 100 MHz clock
    always #5 clock = ~clock;

    dfs_status_regs dut_u (.clock(clock), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .monitorFreq(monitorFreq), .secondPathFreq(secondPathFreq), .monitorAtLimit(monitorAtLimit),
        .secondAtLimit(secondAtLimit), .softFreqAlarm(softFreqAlarm), .hardAlarm(hardAlarm),
        .reportedPllFreqOffset(reportedPllFreqOffset), .irq(irq));

    // Counts, verdict and end of run
    task automatic print_verdict();
        $display("compared %0d, mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // One APB transfer; entered just after a rising edge, ends one edge after completion
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        int k;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        k = 0;
        // Bounded wait so a stuck slave cannot hang the run
        do begin
            @(posedge clock);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 20) begin
            miscompares++;
            print_verdict();
        end
        @(posedge clock);
    endtask

    // Read a register and compare the whole word and the error flag
    task automatic rchk(input logic [7:0] idx, input logic [31:0] ex);
        apb(1'b0, idx, 32'h0);
        `CHK("prdata", ex, rdat)
        `CHK("pslverr", 1'b0, rerr)
    endtask

    // Wait a few cycles for registered inputs to land
    task automatic settle(input int n);
        repeat (n) @(posedge clock);
    endtask

    // Reset values of the reported word and both status bytes
    task automatic t_reset();
        `CHK("freq in reset", FREQ_RST, reportedPllFreqOffset)
        `CHK("irq in reset", 1'b0, irq)
        nrst <= 1'b1;
        settle(2);
        rchk(IDX_FREQ_MID, 32'h0);
        rchk(IDX_VALID_LOW, 32'h0);
    endtask

    // Source select between monitor and second path, signed word passed whole
    task automatic t_select();
        monitorFreq <= 24'h12ab34;
        secondPathFreq <= 24'hfe5678;
        apb(1'b1, IDX_PATH_CFG, 32'h0);
        rchk(IDX_FREQ_MID, 32'h0000_00ab);
        `CHK("monitor word", 24'h12ab34, reportedPllFreqOffset)
        apb(1'b1, IDX_PATH_CFG, 32'h10);
        rchk(IDX_PATH_CFG, 32'h10);
        rchk(IDX_FREQ_MID, 32'h0000_0056);
        `CHK("negative word", 24'hfe5678, reportedPllFreqOffset)
        // Software widens the word as signed before scaling it
        `CHK("signed offset", 32'hfffe5678, 32'($signed(reportedPllFreqOffset)))
    endtask

    // Freeze only on the selected path at its limit, with hold interrupt
    task automatic t_freeze();
        apb(1'b1, IDX_FREEZE_CFG, 32'h08);
        rchk(IDX_FREEZE_CFG, 32'h08);
        monitorAtLimit <= 1'b1;
        secondPathFreq <= 24'hfe9a00;
        settle(2);
        `CHK("unselected limit", 24'hfe9a00, reportedPllFreqOffset)
        secondAtLimit <= 1'b1;
        settle(2);
        secondPathFreq <= 24'h001100;
        settle(3);
        `CHK("held word", 24'hfe9a00, reportedPllFreqOffset)
        rchk(IDX_INT_STATUS, 32'h100);
        apb(1'b1, IDX_INT_MASK, 32'h100);
        `CHK("irq hold", 1'b1, irq)
        apb(1'b1, IDX_FREEZE_CFG, 32'h0);
        settle(1);
        `CHK("released word", 24'h001100, reportedPllFreqOffset)
        apb(1'b1, IDX_INT_STATUS, 32'h100);
        `CHK("irq cleared", 1'b0, irq)
        // Read-only word ignores writes without error
        apb(1'b1, IDX_FREQ_MID, 32'hff);
        `CHK("ro write err", 1'b0, rerr)
        rchk(IDX_FREQ_MID, 32'h11);
        apb(1'b0, 8'h05, 32'h0);
        `CHK("unmapped err", 1'b1, rerr)
        `CHK("unmapped data", 32'h0, rdat)
    endtask

    // Walk one valid input at a time, soft alarms on everywhere
    task automatic t_valid();
        softFreqAlarm <= 8'hff;
        for (int i = 0; i < 8; i++) begin
            hardAlarm <= ~(8'h01 << i);
            settle(3);
            rchk(IDX_VALID_LOW, 32'(8'h01 << i));
        end
        hardAlarm <= 8'h00;
        settle(3);
        rchk(IDX_VALID_LOW, 32'hff);
        rchk(IDX_INT_STATUS, 32'hff);
        `CHK("irq masked", 1'b0, irq)
        apb(1'b1, IDX_INT_MASK, 32'h0ff);
        `CHK("irq unmasked", 1'b1, irq)
        apb(1'b1, IDX_INT_STATUS, 32'h0ff);
        `CHK("irq after clear", 1'b0, irq)
        hardAlarm <= 8'h04;
        settle(3);
        `CHK("irq one change", 1'b1, irq)
        rchk(IDX_INT_STATUS, 32'h04);
        rchk(IDX_VALID_LOW, 32'hfb);
        // Status bit still set; a cleared mask alone must drop the line
        apb(1'b1, IDX_INT_MASK, 32'h0);
        `CHK("irq mask off", 1'b0, irq)
    endtask

    // Main sequence with 12 cycles of reset
    initial begin
        settle(12);
        t_reset();
        t_select();
        t_freeze();
        t_valid();
        print_verdict();
    end
endmodule
